// [rtl/dccu_top.sv]
// dual capture/compare unit: two channels, register port, timer hooks
// assumes the timer value arrives on the system clock, pins are async
module dccu_top
   import dccu_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire dccu_bus_s bus_i,
   output logic [7:0] rdata_o,
   input wire logic [15:0] timer_i,
   input wire logic timer_wr_i,
   input wire logic adc_en_i,
   input wire logic [1:0] pin_i,
   output logic [1:0] cmp_out_o,
   output logic [1:0] flag_o,
   output logic timer_clr_o,
   output logic adc_start_o,
   output logic timer_ovf_block_o,
   output logic [1:0][9:0] pwm_duty_o
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic is_cap(input logic [3:0] m);
      is_cap = (m[3:2] == 2'b01);
   endfunction

   function automatic logic is_cmp(input logic [3:0] m);
      is_cmp = (m[3:2] == 2'b10);
   endfunction

   logic [1:0][7:0] ctrl_r;
   logic [1:0][7:0] low_r;
   logic [1:0][7:0] high_r;
   logic [1:0] flag_r;
   logic [1:0] out_r;
   logic [1:0][3:0] pre_r;
   logic [1:0] s1_r, s2_r, s3_r;
   logic [1:0] lvl_r;
   logic [1:0] trig;
   logic [1:0] hit;
   logic [1:0] ev;
   logic [1:0] wr_ctrl, wr_low, wr_high;
   logic [7:0] rd_nxt;
   logic flag_clr;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   assign wr_ctrl[0] = bus_i.wr && bus_i.addr == {DCCU_IDX_ONE_CTRL, 2'b00};
   assign wr_ctrl[1] = bus_i.wr && bus_i.addr == {DCCU_IDX_TWO_CTRL, 2'b00};
   assign wr_low[0] = bus_i.wr && bus_i.addr == {DCCU_IDX_ONE_LOW, 2'b00};
   assign wr_low[1] = bus_i.wr && bus_i.addr == {DCCU_IDX_TWO_LOW, 2'b00};
   assign wr_high[0] = bus_i.wr && bus_i.addr == {DCCU_IDX_ONE_HIGH, 2'b00};
   assign wr_high[1] = bus_i.wr && bus_i.addr == {DCCU_IDX_TWO_HIGH, 2'b00};
   assign flag_clr = bus_i.wr && bus_i.addr == {DCCU_IDX_FLAGS, 2'b00};

   // ------------------------------------------------------------
   // pin synchroniser, three stages; change counts when 2 and 3 agree
   // ------------------------------------------------------------
   // edges watched regardless of pin direction
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         lvl_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < 2; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               lvl_r[i] <= s3_r[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // per-channel event decode
   // ------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         logic rise, fall;
         rise = (s2_r[i] == s3_r[i]) && s3_r[i] && !lvl_r[i];
         fall = (s2_r[i] == s3_r[i]) && !s3_r[i] && lvl_r[i];
         ev[i] = 1'b0;
         // prescaled edge selection
         unique case (ctrl_r[i][3:0])
            DCCU_M_CAP_FALL: ev[i] = fall;
            DCCU_M_CAP_RISE: ev[i] = rise;
            DCCU_M_CAP_R4: ev[i] = rise && pre_r[i][1:0] == DCCU_PRE4[1:0];
            DCCU_M_CAP_R16: ev[i] = rise && pre_r[i] == DCCU_PRE16;
            default: ev[i] = 1'b0;
         endcase
         // full 16-bit compare each cycle
         hit[i] = is_cmp(ctrl_r[i][3:0]) &&
            {high_r[i], low_r[i]} == timer_i;
         trig[i] = hit[i] && ctrl_r[i][3:0] == DCCU_M_CMP_TRIG;
      end
   end

   // ------------------------------------------------------------
   // capture prescaler counter
   // ------------------------------------------------------------
   // cleared when off or not capturing; kept across prescale change
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_r <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!is_cap(ctrl_r[i][3:0])) begin
               pre_r[i] <= DCCU_PRE_ZERO;
            end else if ((s2_r[i] == s3_r[i]) && s3_r[i] && !lvl_r[i]) begin
               pre_r[i] <= pre_r[i] + DCCU_PRE_ONE;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // control and value registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_r <= '0;
         low_r <= '0;
         high_r <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_ctrl[i]) begin
               ctrl_r[i] <= bus_i.wdata & DCCU_CTRL_MASK;
            end
            // capture wins over a software byte write
            if (ev[i]) begin
               {high_r[i], low_r[i]} <= timer_i;
            end else begin
               if (wr_low[i]) begin
                  low_r[i] <= bus_i.wdata;
               end
               // high byte read-only while in PWM
               if (wr_high[i] && ctrl_r[i][3:2] != 2'b11) begin
                  high_r[i] <= bus_i.wdata;
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // event flags: set beats clear, only software clears
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_r <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (ev[i] || hit[i]) begin
               flag_r[i] <= 1'b1;
            end else if (flag_clr && bus_i.wdata[i]) begin
               flag_r[i] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // compare output latch
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         out_r <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wr_ctrl[i] && bus_i.wdata == DCCU_CTRL_RESET) begin
               out_r[i] <= 1'b0;
            end else if (hit[i] && ctrl_r[i][3:0] == DCCU_M_CMP_HIGH) begin
               out_r[i] <= 1'b1;
            end else if (hit[i] && ctrl_r[i][3:0] == DCCU_M_CMP_LOW) begin
               out_r[i] <= 1'b0;
            end
            // flag-only and trigger modes leave the latch
         end
      end
   end

   // ------------------------------------------------------------
   // trigger outputs toward timer and converter
   // ------------------------------------------------------------
   // a same-cycle timer write wins, so the clear is withheld
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         timer_clr_o <= 1'b0;
         adc_start_o <= 1'b0;
         timer_ovf_block_o <= 1'b0;
      end else begin
         timer_clr_o <= (|trig) && !timer_wr_i;
         adc_start_o <= trig[1] && adc_en_i;
         timer_ovf_block_o <= |trig;
      end
   end

   // ------------------------------------------------------------
   // outputs and read port
   // ------------------------------------------------------------
   always_comb begin
      rd_nxt = 8'h00;
      unique case (bus_i.addr)
         {DCCU_IDX_ONE_LOW, 2'b00}: rd_nxt = low_r[0];
         {DCCU_IDX_ONE_HIGH, 2'b00}: rd_nxt = high_r[0];
         {DCCU_IDX_ONE_CTRL, 2'b00}: rd_nxt = ctrl_r[0];
         {DCCU_IDX_TWO_LOW, 2'b00}: rd_nxt = low_r[1];
         {DCCU_IDX_TWO_HIGH, 2'b00}: rd_nxt = high_r[1];
         {DCCU_IDX_TWO_CTRL, 2'b00}: rd_nxt = ctrl_r[1];
         {DCCU_IDX_FLAGS, 2'b00}: rd_nxt = {6'h00, flag_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   // each channel forms its own duty word from its low byte and control bits 5:4
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= '0;
         cmp_out_o <= '0;
         flag_o <= '0;
         pwm_duty_o <= '0;
      end else begin
         rdata_o <= bus_i.rd ? rd_nxt : 8'h00;
         cmp_out_o <= out_r;
         flag_o <= flag_r;
         for (int i = 0; i < 2; i++) begin
            pwm_duty_o[i] <= {low_r[i],
               ctrl_r[i][DCCU_DUTY_HI], ctrl_r[i][DCCU_DUTY_LO]};
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);

   capture_copies_a: assert property (ev[0] |=>
      {high_r[0], low_r[0]} == $past(timer_i) && flag_r[0])
      else $error("capture did not copy timer");
   flag_sticky_a: assert property (flag_r[0] && !flag_clr |=> flag_r[0])
      else $error("flag cleared by hardware");
   cmp_high_a: assert property (
      hit[0] && ctrl_r[0][3:0] == DCCU_M_CMP_HIGH && !wr_ctrl[0]
      |=> ##1 cmp_out_o[0]) else $error("output not high");
   cmp_low_a: assert property (
      hit[1] && ctrl_r[1][3:0] == DCCU_M_CMP_LOW && !wr_ctrl[1]
      |=> ##1 !cmp_out_o[1]) else $error("output not low");
   flag_only_a: assert property (
      hit[0] && ctrl_r[0][3:0] == DCCU_M_CMP_FLAG && !wr_ctrl[0]
      |=> $stable(out_r[0])) else $error("pin changed in flag mode");
   trig_clear_a: assert property (trig[0] && !timer_wr_i |=>
      timer_clr_o) else $error("trigger missed clear");
   write_wins_a: assert property (timer_wr_i |=> !timer_clr_o)
      else $error("clear beat timer write");
   adc_start_a: assert property (trig[1] && adc_en_i |=> adc_start_o)
      else $error("conversion not started");
   pre_clear_a: assert property (!is_cap(ctrl_r[1][3:0]) |=>
      pre_r[1] == DCCU_PRE_ZERO) else $error("prescaler not cleared");
   zero_ctrl_a: assert property (wr_ctrl[0] && bus_i.wdata == 8'h00
      |=> ##1 !cmp_out_o[0]) else $error("latch not forced low");

   // ------------------------------------------------------------
   // further checks, channel two mirrors and byte port
   // ------------------------------------------------------------

   // channel two capture copies the timer and flags
   cap_copy_two_a: assert property (ev[1] |=>
      {high_r[1], low_r[1]} == $past(timer_i) && flag_r[1])
      else $error("channel two capture did not copy timer");

   // channel two flag only falls by software
   flag_sticky_two_a: assert property (
      flag_r[1] && !flag_clr |=> flag_r[1])
      else $error("channel two flag cleared by hardware");

   // channel two drives its latch high on match
   cmp_high_two_a: assert property (
      hit[1] && ctrl_r[1][3:0] == DCCU_M_CMP_HIGH && !wr_ctrl[1]
      |=> ##1 cmp_out_o[1]) else $error("channel two output not high");

   // channel one drives its latch low on match
   cmp_low_one_a: assert property (
      hit[0] && ctrl_r[0][3:0] == DCCU_M_CMP_LOW && !wr_ctrl[0]
      |=> ##1 !cmp_out_o[0]) else $error("channel one output not low");

   // a match always flags, whatever the pin action
   match_flag_a: assert property (hit[0] |=> flag_r[0])
      else $error("channel one match did not flag");

   // same for channel two
   match_flag_two_a: assert property (hit[1] |=> flag_r[1])
      else $error("channel two match did not flag");

   // channel one prescaler clears outside capture
   pre_clear_one_a: assert property (!is_cap(ctrl_r[0][3:0]) |=>
      pre_r[0] == DCCU_PRE_ZERO) else $error("prescaler one not cleared");

   // every trigger also masks the overflow flag
   ovf_block_a: assert property (|trig |=> timer_ovf_block_o)
      else $error("overflow not masked on trigger");

   // only channel two may start a conversion
   adc_quiet_a: assert property (!trig[1] |=> !adc_start_o)
      else $error("conversion started without channel two");

   // high byte is read-only while in pwm
   pwm_high_ro_a: assert property (
      wr_high[0] && ctrl_r[0][3:2] == 2'b11 |=> $stable(high_r[0]))
      else $error("high byte written in pwm");

   // read port idles at zero without a strobe
   rdata_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
      else $error("read data without strobe");

   // channel two latch forced low by zero control
   zero_ctrl_two_a: assert property (
      wr_ctrl[1] && bus_i.wdata == DCCU_CTRL_RESET
      |=> ##1 !cmp_out_o[1]) else $error("latch two not forced low");

   // low byte takes the written value
   byte_write_a: assert property (wr_low[0] && !ev[0] |=>
      low_r[0] == $past(bus_i.wdata)) else $error("low byte not written");

   // channel two high byte takes the written value outside pwm
   byte_write_two_a: assert property (
      wr_high[1] && !ev[1] && ctrl_r[1][3:2] != 2'b11
      |=> high_r[1] == $past(bus_i.wdata))
      else $error("high byte two not written");

   // mode zero returns the prescaler to reset
   mode_off_a: assert property (
      wr_ctrl[0] && bus_i.wdata == DCCU_CTRL_RESET
      |=> ##1 pre_r[0] == DCCU_PRE_ZERO) else $error("mode off kept state");

   // a capture shows on the flag output two edges later
   cap_flag_out_a: assert property (ev[0] |=> ##1 flag_o[0])
      else $error("capture flag not output");

   // ------------------------------------------------------------
   // covers for the main scenarios
   // ------------------------------------------------------------
   cap_seen_c: cover property (ev[0]);
   trig_seen_c: cover property (trig[1] && adc_en_i);
   high_seen_c: cover property (hit[0] && ctrl_r[0][3:0] == DCCU_M_CMP_HIGH);
   r16_seen_c: cover property (ev[1] && ctrl_r[1][3:0] == DCCU_M_CAP_R16);
   low_seen_c: cover property (hit[1] && ctrl_r[1][3:0] == DCCU_M_CMP_LOW);
endmodule

// [shared/dccu_pkg.sv]
// constants, register map and carriers for the dual capture/compare unit
// assumes one 125 MHz clock; the timer and A/D sit outside the block
// Summary of operation
// - each channel holds two value bytes
// - codes 0100-0111 select capture edge prescale
// - code 1000 drives output high on match
// - code 1001 drives output low on match
// - code 1010 sets flag only, pin unchanged
// - code 1011 pulses hardware trigger on match
// - codes 11xx are PWM with duty bits
// - capture copies timer and sets flag
// - hardware never clears the event flag
// - new capture overwrites unread value
// - edges seen even when pin drives out
// - prescaler cleared when off or not capture
// - prescale change keeps counter, may flag falsely
// - compare every cycle, pin and flag together
// - writing zero control forces output latch low
// - channel one trigger clears the timer
// - channel two trigger clears timer, starts conversion
// - trigger clear never sets overflow flag
// - both PWM channels share eight-bit time-base
// - software timer write beats trigger clear
package dccu_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] DCCU_IDX_ONE_LOW = 8'h15;
   localparam logic [7:0] DCCU_IDX_ONE_HIGH = 8'h16;
   localparam logic [7:0] DCCU_IDX_ONE_CTRL = 8'h17;
   localparam logic [7:0] DCCU_IDX_TWO_LOW = 8'h1b;
   localparam logic [7:0] DCCU_IDX_TWO_HIGH = 8'h1c;
   localparam logic [7:0] DCCU_IDX_TWO_CTRL = 8'h1d;
   // own status register: flags, write one to clear
   localparam logic [7:0] DCCU_IDX_FLAGS = 8'h20;
   localparam int DCCU_AW = 10;
   localparam logic [7:0] DCCU_CTRL_RESET = 8'h00;
   localparam logic [7:0] DCCU_CTRL_MASK = 8'h3f;
   localparam int DCCU_DUTY_HI = 5;
   localparam int DCCU_DUTY_LO = 4;
   localparam logic [3:0] DCCU_PRE4 = 4'h3;
   localparam logic [3:0] DCCU_PRE16 = 4'hf;
   localparam logic [3:0] DCCU_PRE_ZERO = 4'h0;
   localparam logic [3:0] DCCU_PRE_ONE = 4'h1;
   localparam logic [1:0] DCCU_CH_ONE = 2'h1;
   localparam logic [1:0] DCCU_CH_TWO = 2'h2;

   typedef enum logic [3:0] {
      DCCU_M_OFF = 4'b0000,
      DCCU_M_CAP_FALL = 4'b0100,
      DCCU_M_CAP_RISE = 4'b0101,
      DCCU_M_CAP_R4 = 4'b0110,
      DCCU_M_CAP_R16 = 4'b0111,
      DCCU_M_CMP_HIGH = 4'b1000,
      DCCU_M_CMP_LOW = 4'b1001,
      DCCU_M_CMP_FLAG = 4'b1010,
      DCCU_M_CMP_TRIG = 4'b1011
   } dccu_mode_e;

   // register bus request
   typedef struct packed {
      logic [DCCU_AW-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } dccu_bus_s;
endpackage

// [verif/dccu_pin_model.sv]
// stimulus model of the signals arriving on the two channel pins
// assumes the bench calls pulse() from its main sequence
module dccu_pin_model (
   input wire logic clk_sys_i,
   output logic [1:0] pin_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // pin stimulus
   // ----------------------------------------
   initial pin_o = 2'b00;

   // one rising then falling edge; each level held four cycles so it
   // outlives the synchroniser and is never a runt
   task automatic pulse(input int ch);
      repeat (4) @(posedge clk_sys_i);
      pin_o[ch] <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      pin_o[ch] <= 1'b0;
   endtask
endmodule

// [verif/tb_dual_capture_compare_unit.sv]
// self-checking bench for the dual capture/compare unit
// assumes the pin model drives the pins; the bench drives bus and timer
module tb_dual_capture_compare_unit import dccu_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic clk_sys_i = 1'b0;
   logic rstn_i = 1'b0;
   dccu_bus_s bus = '0;
   logic [15:0] timer = 16'h0000;
   logic timer_wr = 1'b0;
   logic adc_en = 1'b1;
   logic [1:0] pin;
   logic [7:0] rdata;
   logic [1:0] cmp_out;
   logic [1:0] flag;
   logic clr;
   logic adc_start;
   logic ovf_blk;
   logic [1:0][9:0] duty;
   logic [15:0] n_clr;
   logic [15:0] n_adc;
   logic [15:0] n_ovf;
   int n_mismatch = 0;
   int checks = 0;

   // free-running 125 MHz clock
   always #4 clk_sys_i = ~clk_sys_i;

   dccu_top i_dccu_top (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .bus_i(bus), .rdata_o(rdata), .timer_i(timer),
      .timer_wr_i(timer_wr), .adc_en_i(adc_en), .pin_i(pin),
      .cmp_out_o(cmp_out), .flag_o(flag), .timer_clr_o(clr),
      .adc_start_o(adc_start), .timer_ovf_block_o(ovf_blk),
      .pwm_duty_o(duty));

   dccu_pin_model i_dccu_pin_model (.clk_sys_i(clk_sys_i), .pin_o(pin));

   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] e);
      checks++;
      if (seen !== e) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, e);
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk_sys_i);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask

   // timer equals v for one cycle; trigger pulses counted afterwards
   // timer moves on the system clock only, never asynchronously
   task automatic match(input logic [15:0] v);
      n_clr = 16'h0000;
      n_adc = 16'h0000;
      n_ovf = 16'h0000;
      @(posedge clk_sys_i);
      timer <= v;
      @(posedge clk_sys_i);
      timer <= v ^ 16'h8000;
      repeat (6) begin
         #1;
         n_clr += clr;
         n_adc += adc_start;
         n_ovf += ovf_blk;
         @(posedge clk_sys_i);
      end
   endtask

   task automatic cap(input int ch);
      i_dccu_pin_model.pulse(ch);
      repeat (8) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic tally_and_finish();
      if (n_mismatch == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      rd(10'h05c, 8'h00);
      rd(10'h074, 8'h00);
      rd(10'h3fc, 8'h00);
      wr(10'h054, 8'h34);
      wr(10'h058, 8'h12);
      rd(10'h054, 8'h34);
      rd(10'h058, 8'h12);
      // pwm: low byte plus control bits 5:4 form the duty
      wr(10'h05c, 8'hff);
      rd(10'h05c, 8'h3f);
      chk(duty[0], {8'h34, 2'b11});
      wr(10'h06c, 8'h5a);
      wr(10'h074, 8'h2c);
      // duty word is registered one edge after the control write lands
      @(posedge clk_sys_i);
      #1 chk(duty[1], {8'h5a, 2'b10});
      wr(10'h074, 8'h00);
      // compare modes on channel one
      wr(10'h05c, 8'h08);
      match(16'h1234);
      chk(cmp_out[0], 1'b1);
      chk(flag[0], 1'b1);
      chk(n_clr, 16'h0000);
      wr(10'h080, 8'h01);
      repeat (3) @(posedge clk_sys_i);
      #1 chk(flag[0], 1'b0);
      wr(10'h05c, 8'h09);
      match(16'h1234);
      chk(cmp_out[0], 1'b0);
      chk(flag[0], 1'b1);
      wr(10'h05c, 8'h08);
      match(16'h1234);
      wr(10'h080, 8'h01);
      wr(10'h05c, 8'h0a);
      match(16'h1234);
      chk(cmp_out[0], 1'b1);
      chk(flag[0], 1'b1);
      wr(10'h05c, 8'h00);
      repeat (3) @(posedge clk_sys_i);
      #1 chk(cmp_out[0], 1'b0);
      // hardware triggers: channel one, channel two, write contention
      wr(10'h05c, 8'h0b);
      match(16'h1234);
      chk(n_clr, 16'h0001);
      chk(n_adc, 16'h0000);
      chk(n_ovf, 16'h0001);
      wr(10'h05c, 8'h00);
      wr(10'h06c, 8'h34);
      wr(10'h070, 8'h12);
      wr(10'h074, 8'h0b);
      match(16'h1234);
      chk(n_clr, 16'h0001);
      chk(n_adc, 16'h0001);
      timer_wr <= 1'b1;
      match(16'h1234);
      chk(n_clr, 16'h0000);
      timer_wr <= 1'b0;
      // compare high then low on channel two
      wr(10'h074, 8'h08);
      match(16'h1234);
      chk(cmp_out[1], 1'b1);
      chk(flag[1], 1'b1);
      wr(10'h074, 8'h09);
      match(16'h1234);
      chk(cmp_out[1], 1'b0);
      wr(10'h074, 8'h00);
      wr(10'h080, 8'h03);
      // capture on rising edge, read it back, then capture again over it
      wr(10'h05c, 8'h05);
      timer <= 16'hbeef;
      cap(0);
      chk(flag[0], 1'b1);
      rd(10'h054, 8'hef);
      rd(10'h058, 8'hbe);
      timer <= 16'hcafe;
      cap(0);
      rd(10'h054, 8'hfe);
      chk(flag[0], 1'b1);
      // falling edge capture
      wr(10'h080, 8'h01);
      wr(10'h05c, 8'h04);
      timer <= 16'h0f0f;
      cap(0);
      rd(10'h058, 8'h0f);
      // every 4th rising edge; turning off clears the prescaler
      wr(10'h05c, 8'h06);
      wr(10'h080, 8'h01);
      cap(0);
      cap(0);
      wr(10'h05c, 8'h00);
      wr(10'h05c, 8'h06);
      // flag cleared after the mode change
      wr(10'h080, 8'h01);
      cap(0);
      cap(0);
      cap(0);
      chk(flag[0], 1'b0);
      cap(0);
      chk(flag[0], 1'b1);
      // every 16th rising edge on channel two
      wr(10'h074, 8'h07);
      wr(10'h080, 8'h02);
      timer <= 16'h5a5a;
      repeat (15) cap(1);
      chk(flag[1], 1'b0);
      cap(1);
      chk(flag[1], 1'b1);
      rd(10'h06c, 8'h5a);
      rd(10'h080, 8'h03);
      tally_and_finish();
   end

   // hang guard
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
